// ==== rtl/smc_strap_mode_config.sv ====
// Strap and control-mode configuration front end of a video link retimer
//
// Behaviour
// - While operation enable is low the block holds power-down, and while high it runs normally.
// - A high-to-low edge on operation enable resets every decoded and programmed setting.
// - Control-mode select high chooses I2C control mode, low chooses pin-strap mode.
// - In pin-strap mode local I2C writes cannot change any strap-controlled function.
// - In pin-strap mode the edge rate strap gives fastest when high, 5 ps slower when low, 10 ps slower when open.
// - In I2C control mode the edge rate strap is ignored and the I2C programmed edge rate is used.
// - The de-emphasis strap gives -2 dB when low and 0 dB when open, and high is reserved.
// - In pin-strap mode the equaliser strap gives 7.5 dB fixed when low, adaptive when open, 14 dB fixed when high.
// - In I2C control mode the equaliser strap is read as slave address bit 0.
// - In pin-strap mode the output format strap selects DVI when high and the richer TMDS format with ID block when low.
// - In I2C control mode the output format strap is read as slave address bit 1.
// - Straps decode three levels in pin-strap mode but only two when they serve as address bits.
// - An undriven output format strap reads low through the weak pull-down and, in pin-strap mode, selects the TMDS format.
`timescale 1ns/10ps
`default_nettype none

`include "smc_cfg.svh"

module smc_strap_mode_config (
  input  wire logic        mclk_in,
  input  wire logic        resetn_in,
  // Operation enable and control-mode select
  input  wire logic        op_enable_in,
  input  wire logic        ctrl_mode_sel_in,
  // Three-level straps as comparator pairs: above the high threshold, below the low threshold
  input  wire logic        edge_rate_strap_hi_in,
  input  wire logic        edge_rate_strap_lo_in,
  input  wire logic        deemph_strap_hi_in,
  input  wire logic        deemph_strap_lo_in,
  input  wire logic        equalizer_strap_addr_lo_hi_in,
  input  wire logic        equalizer_strap_addr_lo_lo_in,
  input  wire logic        output_format_strap_addr_hi_hi_in,
  input  wire logic        output_format_strap_addr_hi_lo_in,
  // Settings written by the local control interface
  input  wire logic        i2c_wr_in,
  input  wire logic [1:0]  i2c_edge_rate_in,
  input  wire logic [1:0]  i2c_eq_mode_in,
  input  wire logic        i2c_format_in,
  // Decoded configuration
  output logic             power_down_out,
  output logic             device_reset_out,
  output logic             cfg_valid_out,
  output logic             i2c_mode_out,
  output logic [1:0]       edge_rate_out,
  output logic [1:0]       deemph_out,
  output logic             deemph_reserved_out,
  output logic [1:0]       eq_mode_out,
  output logic             format_out,
  output logic             adaptor_id_en_out,
  output logic [1:0]       slave_addr_bits_out
);
  import smc_pkg::*;

  // Two-level reading of a strap used as an address bit; an open pin reads as zero
  // An open format pin is the pull-down level anyway, and an open equaliser pin has no defined address
  function automatic logic smc_addr_bit(input smc_level_e lvl);
    smc_addr_bit = (lvl == SMC_LVL_HIGH);
  endfunction : smc_addr_bit

  logic [`SMC_NUM_STRAPS-1:0] strap_hi;
  logic [`SMC_NUM_STRAPS-1:0] strap_lo;
  smc_level_e                 strap_lvl [`SMC_NUM_STRAPS];
  smc_level_e                 held_lvl_q [`SMC_NUM_STRAPS];

  smc_state_e  state_q;
  smc_state_e  state_d;
  logic        op_enable_q;
  logic        mode_i2c_q;
  logic [1:0]  prog_edge_q;
  logic [1:0]  prog_eq_q;
  logic        prog_format_q;

  logic        op_fall;
  logic        running;
  logic        out_live;
  logic [1:0]  edge_rate_d;
  logic [1:0]  deemph_d;
  logic        deemph_rsvd_d;
  logic [1:0]  eq_mode_d;
  logic        format_d;
  logic [1:0]  addr_d;

  assign strap_hi[`SMC_IDX_EDGE]   = edge_rate_strap_hi_in;
  assign strap_lo[`SMC_IDX_EDGE]   = edge_rate_strap_lo_in;
  assign strap_hi[`SMC_IDX_DEEMPH] = deemph_strap_hi_in;
  assign strap_lo[`SMC_IDX_DEEMPH] = deemph_strap_lo_in;
  assign strap_hi[`SMC_IDX_EQ]     = equalizer_strap_addr_lo_hi_in;
  assign strap_lo[`SMC_IDX_EQ]     = equalizer_strap_addr_lo_lo_in;
  assign strap_hi[`SMC_IDX_FORMAT] = output_format_strap_addr_hi_hi_in;
  assign strap_lo[`SMC_IDX_FORMAT] = output_format_strap_addr_hi_lo_in;

  genvar gi;
  generate
    for (gi = 0; gi < `SMC_NUM_STRAPS; gi++) begin : g_strap
      smc_level_dec u_dec (
        .mclk_in       (mclk_in),
        .resetn_in     (resetn_in),
        .above_high_in (strap_hi[gi]),
        .below_low_in  (strap_lo[gi]),
        .level_out     (strap_lvl[gi])
      );
    end
  endgenerate

  // The enable register resets low, so a release with enable already high gives no false fall
  assign op_fall = op_enable_q && !op_enable_in;
  assign running = (state_q == SMC_ST_RUN);

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      op_enable_q <= 1'h0;
    end else begin
      op_enable_q <= op_enable_in;
    end
  end

  // Sequencing: decoders lag the pins by one cycle, so sampling waits one cycle after enable
  always_comb begin
    state_d = state_q;
    case (state_q)
      SMC_ST_OFF: begin
        if (op_enable_in) begin
          state_d = SMC_ST_SAMPLE;
        end
      end
      SMC_ST_SAMPLE: begin
        state_d = op_enable_in ? SMC_ST_RUN : SMC_ST_OFF;
      end
      SMC_ST_RUN: begin
        if (!op_enable_in) begin
          state_d = SMC_ST_OFF;
        end
      end
      default: begin
        state_d = SMC_ST_OFF;
      end
    endcase
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_q <= SMC_ST_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  // Strap and mode capture; held for as long as enable stays high
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mode_i2c_q <= 1'h0;
      for (int i = 0; i < `SMC_NUM_STRAPS; i++) begin
        held_lvl_q[i] <= SMC_LVL_MID;
      end
    end else if (state_q == SMC_ST_SAMPLE && op_enable_in) begin
      mode_i2c_q <= ctrl_mode_sel_in;
      for (int i = 0; i < `SMC_NUM_STRAPS; i++) begin
        held_lvl_q[i] <= strap_lvl[i];
      end
    end
  end

  // Locally programmed settings; writes land only in I2C mode while running
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      prog_edge_q   <= `SMC_SLEW_FAST;
      prog_eq_q     <= `SMC_EQ_ADAPTIVE;
      prog_format_q <= `SMC_FMT_TMDS;
    end else if (op_fall) begin
      prog_edge_q   <= `SMC_SLEW_FAST;
      prog_eq_q     <= `SMC_EQ_ADAPTIVE;
      prog_format_q <= `SMC_FMT_TMDS;
    end else if (running && mode_i2c_q && i2c_wr_in) begin
      prog_edge_q   <= i2c_edge_rate_in;
      prog_eq_q     <= i2c_eq_mode_in;
      prog_format_q <= i2c_format_in;
    end
  end

  // Decoding of the held straps
  always_comb begin
    edge_rate_d   = `SMC_SLEW_FAST;
    deemph_d      = `SMC_DEEMPH_0DB;
    deemph_rsvd_d = 1'h0;
    eq_mode_d     = `SMC_EQ_ADAPTIVE;
    format_d      = `SMC_FMT_TMDS;
    addr_d        = `SMC_ADDR_RESET;
    if (mode_i2c_q) begin
      edge_rate_d = prog_edge_q;
      eq_mode_d   = prog_eq_q;
      format_d    = prog_format_q;
      addr_d[0]   = smc_addr_bit(held_lvl_q[`SMC_IDX_EQ]);
      addr_d[1]   = smc_addr_bit(held_lvl_q[`SMC_IDX_FORMAT]);
    end else begin
      case (held_lvl_q[`SMC_IDX_EDGE])
        SMC_LVL_HIGH: edge_rate_d = `SMC_SLEW_FAST;
        SMC_LVL_LOW:  edge_rate_d = `SMC_SLEW_5PS;
        default:      edge_rate_d = `SMC_SLEW_10PS;
      endcase
      case (held_lvl_q[`SMC_IDX_EQ])
        SMC_LVL_LOW:  eq_mode_d = `SMC_EQ_FIXED_7P5;
        SMC_LVL_HIGH: eq_mode_d = `SMC_EQ_FIXED_14;
        default:      eq_mode_d = `SMC_EQ_ADAPTIVE;
      endcase
      // An open format pin is pulled low inside, so only a firm high picks DVI
      format_d = (held_lvl_q[`SMC_IDX_FORMAT] == SMC_LVL_HIGH) ? `SMC_FMT_DVI : `SMC_FMT_TMDS;
    end
    // High on this strap is reserved; it is flagged and falls back to no de-emphasis
    case (held_lvl_q[`SMC_IDX_DEEMPH])
      SMC_LVL_LOW: deemph_d = `SMC_DEEMPH_2DB;
      SMC_LVL_MID: deemph_d = `SMC_DEEMPH_0DB;
      default: begin
        deemph_d      = `SMC_DEEMPH_0DB;
        deemph_rsvd_d = 1'h1;
      end
    endcase
  end

  // Power-down and reset indications
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      power_down_out   <= 1'h1;
      device_reset_out <= 1'h0;
    end else begin
      power_down_out   <= !op_enable_in;
      device_reset_out <= op_fall;
    end
  end

  // Configuration outputs stay at defaults unless running; a falling enable clears them on the
  // same edge, so downstream logic never acts on a stale setting after power-down
  assign out_live = running && op_enable_in;

  // Validity and the captured control mode
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cfg_valid_out <= 1'h0;
      i2c_mode_out  <= 1'h0;
    end else if (out_live) begin
      cfg_valid_out <= 1'h1;
      i2c_mode_out  <= mode_i2c_q;
    end else begin
      cfg_valid_out <= 1'h0;
      i2c_mode_out  <= 1'h0;
    end
  end

  // Link settings: edge rate, de-emphasis and receive equalisation
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      edge_rate_out       <= `SMC_SLEW_FAST;
      deemph_out          <= `SMC_DEEMPH_0DB;
      deemph_reserved_out <= 1'h0;
      eq_mode_out         <= `SMC_EQ_ADAPTIVE;
    end else if (out_live) begin
      edge_rate_out       <= edge_rate_d;
      deemph_out          <= deemph_d;
      deemph_reserved_out <= deemph_rsvd_d;
      eq_mode_out         <= eq_mode_d;
    end else begin
      edge_rate_out       <= `SMC_SLEW_FAST;
      deemph_out          <= `SMC_DEEMPH_0DB;
      deemph_reserved_out <= 1'h0;
      eq_mode_out         <= `SMC_EQ_ADAPTIVE;
    end
  end

  // Output format and the identification block that only the TMDS format offers
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      format_out        <= `SMC_FMT_TMDS;
      adaptor_id_en_out <= 1'h0;
    end else if (out_live) begin
      format_out        <= format_d;
      adaptor_id_en_out <= (format_d == `SMC_FMT_TMDS);
    end else begin
      format_out        <= `SMC_FMT_TMDS;
      adaptor_id_en_out <= 1'h0;
    end
  end

  // Strappable slave address bits; zero whenever they do not apply
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      slave_addr_bits_out <= `SMC_ADDR_RESET;
    end else if (out_live) begin
      slave_addr_bits_out <= addr_d;
    end else begin
      slave_addr_bits_out <= `SMC_ADDR_RESET;
    end
  end

endmodule : smc_strap_mode_config

`default_nettype wire

// ==== rtl/smc_cfg.svh ====
// Constants for the strap and mode configuration front end
`ifndef SMC_CFG_SVH
`define SMC_CFG_SVH

// Number of strap pins that pass through a level decoder
`define SMC_NUM_STRAPS     4
// Index of each strap in the decoder array
`define SMC_IDX_EDGE       0
`define SMC_IDX_DEEMPH     1
`define SMC_IDX_EQ         2
`define SMC_IDX_FORMAT     3

// Edge rate codes
`define SMC_SLEW_FAST      2'h0
`define SMC_SLEW_5PS       2'h1
`define SMC_SLEW_10PS      2'h2

// De-emphasis codes
`define SMC_DEEMPH_0DB     2'h0
`define SMC_DEEMPH_2DB     2'h1
`define SMC_DEEMPH_RSVD    2'h2

// Receive equalisation codes
`define SMC_EQ_ADAPTIVE    2'h0
`define SMC_EQ_FIXED_7P5   2'h1
`define SMC_EQ_FIXED_14    2'h2

// Output format codes
`define SMC_FMT_TMDS       1'h0
`define SMC_FMT_DVI        1'h1

// Address strap bit reset value
`define SMC_ADDR_RESET     2'h0

`endif

// ==== rtl/smc_pkg.sv ====
// Types shared by the strap and mode configuration front end
`default_nettype none

package smc_pkg;

  typedef enum logic [1:0] {
    SMC_LVL_LOW,
    SMC_LVL_MID,
    SMC_LVL_HIGH
  } smc_level_e;

  typedef enum logic [1:0] {
    SMC_ST_OFF,
    SMC_ST_SAMPLE,
    SMC_ST_RUN
  } smc_state_e;

endpackage : smc_pkg

`default_nettype wire

// ==== rtl/smc_level_dec.sv ====
// Three-level strap decoder from a pair of threshold comparator bits
`timescale 1ns/10ps
`default_nettype none

module smc_level_dec (
  input  wire logic              mclk_in,
  input  wire logic              resetn_in,
  input  wire logic              above_high_in,
  input  wire logic              below_low_in,
  output var smc_pkg::smc_level_e level_out
);
  import smc_pkg::*;

  smc_level_e level_d;

  // A pin seen both above and below is not physical; treat it as floating
  always_comb begin
    if (above_high_in && !below_low_in) begin
      level_d = SMC_LVL_HIGH;
    end else if (below_low_in && !above_high_in) begin
      level_d = SMC_LVL_LOW;
    end else begin
      level_d = SMC_LVL_MID;
    end
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      level_out <= SMC_LVL_MID;
    end else begin
      level_out <= level_d;
    end
  end

endmodule : smc_level_dec

`default_nettype wire

// ==== tb/smc_chk_assertions.sv ====
// Port checker for the strap and mode front end
`timescale 1ns/10ps
`default_nettype none
`include "smc_cfg.svh"
module smc_chk (
  input wire logic       mclk_in,
  input wire logic       resetn_in,
  input wire logic       op_enable_in,
  input wire logic       ctrl_mode_sel_in,
  input wire logic       i2c_wr_in,
  input wire logic [1:0] i2c_edge_rate_in,
  input wire logic [1:0] i2c_eq_mode_in,
  input wire logic       i2c_format_in,
  input wire logic       power_down_out,
  input wire logic       device_reset_out,
  input wire logic       cfg_valid_out,
  input wire logic       i2c_mode_out,
  input wire logic [1:0] edge_rate_out,
  input wire logic [1:0] deemph_out,
  input wire logic       deemph_reserved_out,
  input wire logic [1:0] eq_mode_out,
  input wire logic       format_out,
  input wire logic       adaptor_id_en_out,
  input wire logic [1:0] slave_addr_bits_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);
  property p_off; !op_enable_in |=> power_down_out; endproperty
  a_off: assert property (p_off) else $error("power down missing");
  property p_on; op_enable_in |=> !power_down_out; endproperty
  a_on: assert property (p_on) else $error("power down stuck");
  property p_fall;
    $fell(op_enable_in) |=> device_reset_out && power_down_out && !cfg_valid_out ##1 !device_reset_out;
  endproperty
  a_fall: assert property (p_fall) else $error("bad reset on enable fall");
  property p_valid;
    $rose(op_enable_in) ##1 op_enable_in ##1 op_enable_in |=>
      cfg_valid_out && i2c_mode_out == $past(ctrl_mode_sel_in, 2);
  endproperty
  a_valid: assert property (p_valid) else $error("mode not sampled");
  property p_hold;
    cfg_valid_out && $past(cfg_valid_out) && !i2c_mode_out |->
      $stable(edge_rate_out) && $stable(eq_mode_out) && $stable(format_out);
  endproperty
  a_hold: assert property (p_hold) else $error("strap setting moved");
  // Write must land two edges later unless enable falls in between
  property p_wr;
    cfg_valid_out && i2c_mode_out && i2c_wr_in && op_enable_in ##1 op_enable_in |=>
      edge_rate_out == $past(i2c_edge_rate_in, 2) && eq_mode_out == $past(i2c_eq_mode_in, 2)
      && format_out == $past(i2c_format_in, 2);
  endproperty
  a_wr: assert property (p_wr) else $error("write not applied");
  property p_addr; cfg_valid_out && !i2c_mode_out |-> slave_addr_bits_out == `SMC_ADDR_RESET; endproperty
  a_addr: assert property (p_addr) else $error("address in strap mode");
  property p_aid; cfg_valid_out |-> adaptor_id_en_out == (format_out == `SMC_FMT_TMDS); endproperty
  a_aid: assert property (p_aid) else $error("id block enable wrong");
  property p_rsvd; deemph_reserved_out |-> deemph_out == `SMC_DEEMPH_0DB; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved level not 0 dB");
endmodule : smc_chk
`default_nettype wire

// ==== tb/smc_board.sv ====
// Board straps seen through the pin comparator pairs
`timescale 1ns/10ps
`default_nettype none
module smc_board (
  input  wire logic [7:0] lvl_in,
  output logic [3:0]      hi_out,
  output logic [3:0]      lo_out
);
  import smc_pkg::*;
  // Open pin sits between thresholds, so neither comparator trips
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      hi_out[i] = lvl_in[2*i+:2] == SMC_LVL_HIGH;
      lo_out[i] = lvl_in[2*i+:2] == SMC_LVL_LOW;
    end
  end
endmodule : smc_board
`default_nettype wire

// ==== tb/smc_strap_mode_config_bench.sv ====
// Bench for the strap and mode front end
`timescale 1ns/10ps
`default_nettype none
module smc_strap_mode_config_bench;
  import smc_pkg::*;
  localparam logic [1:0] L = SMC_LVL_LOW;
  localparam logic [1:0] M = SMC_LVL_MID;
  localparam logic [1:0] H = SMC_LVL_HIGH;
  typedef struct packed {logic m; logic [7:0] lv; logic [10:0] ex;} smc_row_s;
  logic        mclk_in = 1'h0;
  logic        resetn_in = 1'h0;
  logic        op_en = 1'h0;
  logic        mode = 1'h0;
  logic        wr = 1'h0;
  logic [4:0]  wd = 5'h00;
  logic [7:0]  lvl = 8'h00;
  logic [3:0]  s_hi;
  logic [3:0]  s_lo;
  logic        pd, rst_p, valid, i2c_m, rsvd, fmt, aid;
  logic [1:0]  er, de, eq, addr;
  int          error_cnt = 0;
  int          compares = 0;
  int          cyc = 0;
  wire logic [10:0] obs = {er, de, rsvd, eq, fmt, aid, addr};
  // Levels packed {format, eq, deemph, edge}; expected {edge, deemph, rsvd, eq, fmt, id, addr}
  smc_row_s rows [7] = '{
    '{1'h0, {H,L,L,H}, {2'h0,2'h1,1'h0,2'h1,1'h1,1'h0,2'h0}},
    '{1'h0, {L,M,M,L}, {2'h1,2'h0,1'h0,2'h0,1'h0,1'h1,2'h0}},
    '{1'h0, {M,H,H,M}, {2'h2,2'h0,1'h1,2'h2,1'h0,1'h1,2'h0}},
    '{1'h1, {H,H,L,L}, {2'h0,2'h1,1'h0,2'h0,1'h0,1'h1,2'h3}},
    '{1'h1, {M,M,M,M}, {2'h0,2'h0,1'h0,2'h0,1'h0,1'h1,2'h0}},
    '{1'h1, {L,H,M,H}, {2'h0,2'h0,1'h0,2'h0,1'h0,1'h1,2'h1}},
    '{1'h1, {H,L,H,M}, {2'h0,2'h0,1'h1,2'h0,1'h0,1'h1,2'h2}}};
  smc_board brd_u (.lvl_in(lvl), .hi_out(s_hi), .lo_out(s_lo));
  smc_strap_mode_config dut_u (.mclk_in(mclk_in), .resetn_in(resetn_in), .op_enable_in(op_en),
    .ctrl_mode_sel_in(mode), .edge_rate_strap_hi_in(s_hi[0]), .edge_rate_strap_lo_in(s_lo[0]),
    .deemph_strap_hi_in(s_hi[1]), .deemph_strap_lo_in(s_lo[1]), .equalizer_strap_addr_lo_hi_in(s_hi[2]),
    .equalizer_strap_addr_lo_lo_in(s_lo[2]), .output_format_strap_addr_hi_hi_in(s_hi[3]),
    .output_format_strap_addr_hi_lo_in(s_lo[3]), .i2c_wr_in(wr), .i2c_edge_rate_in(wd[4:3]),
    .i2c_eq_mode_in(wd[2:1]), .i2c_format_in(wd[0]), .power_down_out(pd), .device_reset_out(rst_p),
    .cfg_valid_out(valid), .i2c_mode_out(i2c_m), .edge_rate_out(er), .deemph_out(de),
    .deemph_reserved_out(rsvd), .eq_mode_out(eq), .format_out(fmt), .adaptor_id_en_out(aid),
    .slave_addr_bits_out(addr));
  always #50 mclk_in = ~mclk_in;
  task automatic results();
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : results
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 2000) begin
      error_cnt++;
      results();
    end
  end
  task automatic chk(input string n, input logic [10:0] s, input logic [10:0] e);
    compares++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // Straps settle two cycles before enable so the decoders are past their latency
  task automatic run(input logic m, input logic [7:0] lv);
    mode = m;
    lvl = lv;
    repeat (2) @(negedge mclk_in);
    op_en = 1'h1;
    repeat (4) @(negedge mclk_in);
  endtask : run
  task automatic stop();
    op_en = 1'h0;
    @(negedge mclk_in);
    chk("fall", {8'h00, rst_p, pd, valid}, 11'h006);
    @(negedge mclk_in);
    chk("pulse", {10'h000, rst_p}, 11'h000);
  endtask : stop
  task automatic put2(input logic [4:0] a, input logic [4:0] b);
    wd = a;
    wr = 1'h1;
    @(negedge mclk_in);
    wd = b;
    @(negedge mclk_in);
    wr = 1'h0;
  endtask : put2
  initial begin
    repeat (3) @(negedge mclk_in);
    chk("reset", {9'h000, pd, valid}, 11'h002);
    resetn_in = 1'h1;
    for (int i = 0; i < 7; i++) begin
      run(rows[i].m, rows[i].lv);
      chk("row", obs, rows[i].ex);
      chk("mode", {10'h000, i2c_m}, {10'h000, rows[i].m});
      stop();
    end
    run(1'h1, {H,H,L,L});
    put2({2'h2,2'h2,1'h1}, {2'h1,2'h2,1'h1});
    lvl = {L,L,L,L};
    mode = 1'h0;
    repeat (3) @(negedge mclk_in);
    chk("prog", obs, {2'h1,2'h1,1'h0,2'h2,1'h1,1'h0,2'h3});
    stop();
    run(1'h1, {L,L,M,L});
    chk("clear", obs, {2'h0,2'h0,1'h0,2'h0,1'h0,1'h1,2'h0});
    stop();
    run(1'h0, {H,L,L,H});
    put2({2'h2,2'h2,1'h0}, {2'h2,2'h2,1'h0});
    repeat (3) @(negedge mclk_in);
    chk("strap", obs, rows[0].ex);
    stop();
    // Enable dropped while sampling still gives the reset pulse and never reports valid
    mode = 1'h1;
    op_en = 1'h1;
    @(negedge mclk_in);
    stop();
    // Writes before the block runs are refused
    op_en = 1'h1;
    put2({2'h2,2'h2,1'h1}, {2'h2,2'h2,1'h1});
    repeat (2) @(negedge mclk_in);
    chk("early", obs, {2'h0,2'h1,1'h0,2'h0,1'h0,1'h1,2'h2});
    // Asynchronous reset in mid-run, then straps sampled afresh on release
    resetn_in = 1'h0;
    @(negedge mclk_in);
    chk("areset", obs, 11'h000);
    chk("areset_pd", {8'h00, rst_p, pd, valid}, 11'h002);
    mode = 1'h0;
    lvl = {M,H,H,M};
    @(negedge mclk_in);
    resetn_in = 1'h1;
    repeat (4) @(negedge mclk_in);
    chk("rerun", obs, rows[2].ex);
    stop();
    results();
  end
endmodule : smc_strap_mode_config_bench
bind smc_strap_mode_config smc_chk chk_u (
  .mclk_in             (mclk_in),
  .resetn_in           (resetn_in),
  .op_enable_in        (op_enable_in),
  .ctrl_mode_sel_in    (ctrl_mode_sel_in),
  .i2c_wr_in           (i2c_wr_in),
  .i2c_edge_rate_in    (i2c_edge_rate_in),
  .i2c_eq_mode_in      (i2c_eq_mode_in),
  .i2c_format_in       (i2c_format_in),
  .power_down_out      (power_down_out),
  .device_reset_out    (device_reset_out),
  .cfg_valid_out       (cfg_valid_out),
  .i2c_mode_out        (i2c_mode_out),
  .edge_rate_out       (edge_rate_out),
  .deemph_out          (deemph_out),
  .deemph_reserved_out (deemph_reserved_out),
  .eq_mode_out         (eq_mode_out),
  .format_out          (format_out),
  .adaptor_id_en_out   (adaptor_id_en_out),
  .slave_addr_bits_out (slave_addr_bits_out)
);
`default_nettype wire
